// ==== rtc_cfg.svh ====
// constants of the interrupt, divider, square-wave and update-cycle block
// ****************************************************************************
// Contract
// - six interrupt sources, each with its own enable bit
// - a source drives the request only while its enable bit is 1
// - enabling a source whose flag is already set asserts the request at once
// - every event sets its flag regardless of the enable bit
// - reading the primary flags clears periodic, alarm and update-done flags
// - primary flags stay stable during a read; events then are held, not lost
// - extended flags survive reads and clear only by writing 0 to them
// - request stays low while any source has flag and enable both set
// - pending flag reads 1 exactly while an enabled source drives the request
// - divider field 01X runs, 11X holds chain in reset, others stop oscillator
// - square output enabled by enable or fast select; fast select gives 32.768kHz, here only while the divider field is 01X
// - with fast select off, rate code picks one of 13 taps, 0000 none
// - without main supply, fast output only with fast select, aux enable, aux battery
// - rate code also sets periodic interrupt period, 0000 none, own enable
// - an update cycle runs every second whatever the freeze bit holds
// - while frozen the user copy of time holds, the internal copy advances
// - each update compares alarm bytes with time bytes and raises an alarm on a match
// - update pending rises 244us before the transfer, pulsing once per second while not frozen
// - update-done flag is raised after every update cycle
// - update pending is high only between successive periodic flag settings, except with rate codes 0011, 0100 and 0101
// - alarm byte with both top bits 1 is don't-care
// - with square enable and fast select both 0 the square pin is low
// - first update comes 500ms after the running pattern is written in place of the hold pattern or after reset
// - freeze bit rising clears the update interrupt enable
// ****************************************************************************
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// divider control patterns, bit 0 is the bank select and is ignored
`define DIV_RUN_PAT 2'b01
`define DIV_HOLD_PAT 2'b11
`define DIV_CTRL_RESET 3'b010
`define RATE_RESET 4'h0
`define RATE_NONE 4'h0

// divider chain: one tick per crystal edge, wraps once a second
`define OSC_EDGE_HZ 65536
`define CHAIN_W 16
`define CHAIN_HOLD_VAL 16'h8000
`define CHAIN_LAST 16'hffff
`define PRE_UPDATE_US 244
`define PRE_UPDATE_TICKS ((`PRE_UPDATE_US * `OSC_EDGE_HZ + 999999) / 1000000)

// primary control byte layout
`define CB_FREEZE 7
`define CB_PIE 6
`define CB_AIE 5
`define CB_UIE 4
`define CB_SQUARE_OUT_EN 3
`define CTRL_B_RESET 8'h08

// extended control byte layout
`define XC_ABE 7
`define XC_FAST_CLK_OUT_SEL 6
`define XC_WIE 2
`define XC_KSE 1
`define XC_RIE 0
`define EXT_CTRL_RESET 8'h00

// extended flag byte layout
`define XF_WF 2
`define XF_KF 1
`define XF_RF 0

// time limits and alarm don't-care code
`define SEC_MAX 8'h3b
`define MIN_MAX 8'h3b
`define HR_MAX 8'h17
`define DONT_CARE 2'b11

`endif

// ==== rtc_pkg.sv ====
// types shared by the rtc interrupt and timebase modules
package rtc_pkg;
  typedef enum logic {RD_IDLE, RD_ACTIVE} rd_state_t;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] rate_t;
endpackage : rtc_pkg

// ==== rtc_div_if.sv ====
// carrier between the control logic and the divider chain
`timescale 1ns/1ps
interface rtc_div_if;
  logic run;
  logic hold;
  logic [3:0] rate;
  logic [15:0] chain;
  logic tap;
  logic per_event;
  logic sec_event;
  logic pre_update;
  modport ctrl (output run, output hold, output rate, input chain, input tap, input per_event,
    input sec_event, input pre_update);
  modport chain_side (input run, input hold, input rate, output chain, output tap,
    output per_event, output sec_event, output pre_update);
endinterface : rtc_div_if

// ==== rtc_divider.sv ====
// sixteen-stage divider chain with tap select and second/update markers
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_divider (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // oscillator edge tick
  input wire logic osc_tick,
  // control side
  rtc_div_if.chain_side d
);
  import rtc_pkg::*;

  logic [15:0] chain;
  logic [15:0] next_chain;
  logic tap_prev;

  // tap index per rate code: 1 and 2 reuse the 256/128 Hz taps
  function automatic logic [3:0] tap_index(input rate_t r);
    if (r == 4'h1) begin
      tap_index = 4'h7;
    end else if (r == 4'h2) begin
      tap_index = 4'h8;
    end else begin
      tap_index = r - 4'h1;
    end
  endfunction : tap_index

  assign next_chain = chain + 16'h0001;
  assign d.chain = chain;
  assign d.tap = (d.rate == `RATE_NONE) ? 1'b0 : chain[tap_index(d.rate)];
  // update pending covers the last 244us before the wrap
  assign d.pre_update = d.run && (chain >= (16'(`CHAIN_LAST) - 16'(`PRE_UPDATE_TICKS) + 16'h0001));

  // chain: held mid-way in reset so the first wrap is half a second away
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chain <= `CHAIN_HOLD_VAL;
    end else if (ce) begin
      if (d.hold) begin
        chain <= `CHAIN_HOLD_VAL;
      end else if (d.run && osc_tick) begin
        chain <= next_chain;
      end
    end
  end

  // periodic and second events, one cycle each
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tap_prev <= 1'b0;
      d.per_event <= 1'b0;
      d.sec_event <= 1'b0;
    end else if (ce) begin
      tap_prev <= d.tap;
      d.per_event <= d.tap && !tap_prev && d.run;
      d.sec_event <= d.run && osc_tick && (chain == `CHAIN_LAST);
    end
  end
endmodule : rtc_divider

// ==== rtc_irq_sqw_update_ctrl.sv ====
// interrupt aggregation, oscillator control, square wave and update cycle
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_irq_sqw_update_ctrl (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // oscillator edge tick, one per crystal edge
  input wire logic osc_tick,
  // supplies
  input wire logic main_power_ok,
  input wire logic aux_battery_in,
  // host control writes
  input wire logic reg_a_wr,
  input wire rtc_pkg::byte_t reg_a_wdata,
  input wire logic reg_b_wr,
  input wire rtc_pkg::byte_t reg_b_wdata,
  input wire logic ext_ctrl_wr,
  input wire rtc_pkg::byte_t ext_ctrl_wdata,
  input wire logic ext_flag_wr,
  input wire rtc_pkg::byte_t ext_flag_wdata,
  // primary flag read cycle, high for the whole read
  input wire logic flag_rd,
  // external event pulses
  input wire logic wake_event,
  input wire logic kick_event,
  input wire logic ram_clear_event,
  // time load and alarm settings
  input wire logic time_load,
  input wire rtc_pkg::byte_t time_in_sec,
  input wire rtc_pkg::byte_t time_in_min,
  input wire rtc_pkg::byte_t time_in_hr,
  input wire rtc_pkg::byte_t alarm_sec,
  input wire rtc_pkg::byte_t alarm_min,
  input wire rtc_pkg::byte_t alarm_hr,
  // register readback
  output rtc_pkg::byte_t reg_a_rd,
  output rtc_pkg::byte_t reg_b_rd,
  output rtc_pkg::byte_t primary_flag_rd,
  output rtc_pkg::byte_t ext_ctrl_rd,
  output rtc_pkg::byte_t ext_flag_rd,
  // user copy of time
  output rtc_pkg::byte_t time_sec,
  output rtc_pkg::byte_t time_min,
  output rtc_pkg::byte_t time_hr,
  // pins
  output logic irq_n_out,
  output logic irq_n_oe,
  output logic square_out_pin
);
  import rtc_pkg::*;

  // ****************************************************************************
  // state
  // ****************************************************************************
  rtc_div_if div ();

  logic [2:0] divider_ctrl;
  rate_t rate_select;
  logic freeze;
  logic periodic_int_en;
  logic alarm_int_en;
  logic update_int_en;
  logic square_out_en;
  logic aux_batt_enable;
  logic fast_clk_out_sel;
  logic wake_int_en;
  logic kick_int_en;
  logic ram_clear_int_en;
  logic periodic_flag;
  logic alarm_flag;
  logic update_done_flag;
  logic [2:0] held_flags;
  logic wake_flag;
  logic kick_flag;
  logic ram_clear_flag;
  logic int_pending_flag;
  logic update_pending;
  rd_state_t rd_state;
  byte_t int_sec;
  byte_t int_min;
  byte_t int_hr;
  byte_t next_sec;
  byte_t next_min;
  byte_t next_hr;
  logic alarm_event;
  logic next_pending;
  logic next_periodic_en;
  logic next_alarm_en;
  logic next_update_en;
  logic next_wake_en;
  logic next_kick_en;
  logic next_ram_en;
  logic next_square;

  // alarm byte matches its time byte or holds the don't-care code
  function automatic logic byte_match(input byte_t alarm, input byte_t tm);
    byte_match = (alarm[7:6] == `DONT_CARE) || (alarm == tm);
  endfunction : byte_match

  // ****************************************************************************
  // divider chain
  // ****************************************************************************
  // only 01X runs; 11X keeps the oscillator going with the chain in reset
  assign div.run = (divider_ctrl[2:1] == `DIV_RUN_PAT);
  assign div.hold = (divider_ctrl[2:1] == `DIV_HOLD_PAT);
  assign div.rate = rate_select;

  rtc_divider u_divider (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .osc_tick(osc_tick),
    .d(div.chain_side)
  );

  // ****************************************************************************
  // control registers
  // ****************************************************************************
  // rate and divider field; bit 0 of the divider field only selects the bank
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divider_ctrl <= `DIV_CTRL_RESET;
      rate_select <= `RATE_RESET;
    end else if (ce && reg_a_wr) begin
      divider_ctrl <= reg_a_wdata[6:4];
      rate_select <= reg_a_wdata[3:0];
    end
  end

  // primary control; freeze rising also knocks out the update interrupt enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      freeze <= 1'(`CTRL_B_RESET >> `CB_FREEZE);
      periodic_int_en <= 1'b0;
      alarm_int_en <= 1'b0;
      update_int_en <= 1'b0;
      square_out_en <= 1'b1;
    end else if (ce && reg_b_wr) begin
      freeze <= reg_b_wdata[`CB_FREEZE];
      periodic_int_en <= reg_b_wdata[`CB_PIE];
      alarm_int_en <= reg_b_wdata[`CB_AIE];
      update_int_en <= next_update_en;
      square_out_en <= reg_b_wdata[`CB_SQUARE_OUT_EN];
    end
  end

  assign next_update_en = reg_b_wdata[`CB_UIE] && !(reg_b_wdata[`CB_FREEZE] && !freeze);

  // extended control: aux battery, fast output select and three enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aux_batt_enable <= 1'b0;
      fast_clk_out_sel <= 1'b0;
      wake_int_en <= 1'b0;
      kick_int_en <= 1'b0;
      ram_clear_int_en <= 1'b0;
    end else if (ce && ext_ctrl_wr) begin
      aux_batt_enable <= ext_ctrl_wdata[`XC_ABE];
      fast_clk_out_sel <= ext_ctrl_wdata[`XC_FAST_CLK_OUT_SEL];
      wake_int_en <= ext_ctrl_wdata[`XC_WIE];
      kick_int_en <= ext_ctrl_wdata[`XC_KSE];
      ram_clear_int_en <= ext_ctrl_wdata[`XC_RIE];
    end
  end

  // ****************************************************************************
  // time keeping and update cycle
  // ****************************************************************************
  // internal copy advances each second; wraps are plain binary counts
  always_comb begin
    next_sec = int_sec;
    next_min = int_min;
    next_hr = int_hr;
    if (int_sec >= `SEC_MAX) begin
      next_sec = 8'h00;
      if (int_min >= `MIN_MAX) begin
        next_min = 8'h00;
        next_hr = (int_hr >= `HR_MAX) ? 8'h00 : int_hr + 8'h01;
      end else begin
        next_min = int_min + 8'h01;
      end
    end else begin
      next_sec = int_sec + 8'h01;
    end
  end

  // alarm is judged against the time that the update produces
  assign alarm_event = div.sec_event && byte_match(alarm_sec, next_sec) && byte_match(alarm_min, next_min)
    && byte_match(alarm_hr, next_hr);

  // internal copy advances on every update, frozen or not; user copy only advances while not frozen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_sec <= 8'h00;
      int_min <= 8'h00;
      int_hr <= 8'h00;
      time_sec <= 8'h00;
      time_min <= 8'h00;
      time_hr <= 8'h00;
    end else if (ce) begin
      if (time_load) begin
        int_sec <= time_in_sec;
        int_min <= time_in_min;
        int_hr <= time_in_hr;
        time_sec <= time_in_sec;
        time_min <= time_in_min;
        time_hr <= time_in_hr;
      end else if (div.sec_event) begin
        int_sec <= next_sec;
        int_min <= next_min;
        int_hr <= next_hr;
        if (!freeze) begin
          time_sec <= next_sec;
          time_min <= next_min;
          time_hr <= next_hr;
        end
      end
    end
  end

  // update pending: pre-update window of the chain, cleared while frozen;
  // it lies inside one periodic interval for rate codes other than 0011, 0100 and 0101, as both come off the same chain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      update_pending <= 1'b0;
    end else if (ce) begin
      update_pending <= div.pre_update && !freeze;
    end
  end

  // ****************************************************************************
  // primary flags with double latching across a read
  // ****************************************************************************
  // at read start the readback freezes and the flags clear; events during the
  // read collect in held_flags and land only when the read ends
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_state <= RD_IDLE;
      periodic_flag <= 1'b0;
      alarm_flag <= 1'b0;
      update_done_flag <= 1'b0;
      held_flags <= 3'h0;
    end else if (ce) begin
      case (rd_state)
        RD_IDLE: begin
          if (flag_rd) begin
            rd_state <= RD_ACTIVE;
            periodic_flag <= 1'b0;
            alarm_flag <= 1'b0;
            update_done_flag <= 1'b0;
            held_flags <= {div.per_event, alarm_event, div.sec_event};
          end else begin
            periodic_flag <= periodic_flag | div.per_event;
            alarm_flag <= alarm_flag | alarm_event;
            update_done_flag <= update_done_flag | div.sec_event;
          end
        end
        RD_ACTIVE: begin
          if (flag_rd) begin
            held_flags <= held_flags | {div.per_event, alarm_event, div.sec_event};
          end else begin
            rd_state <= RD_IDLE;
            periodic_flag <= held_flags[2] | div.per_event;
            alarm_flag <= held_flags[1] | alarm_event;
            update_done_flag <= held_flags[0] | div.sec_event;
            held_flags <= 3'h0;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************************
  // extended flags
  // ****************************************************************************
  // reads leave these alone; a written 0 clears, a same-cycle event wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_flag <= 1'b0;
      kick_flag <= 1'b0;
      ram_clear_flag <= 1'b0;
    end else if (ce) begin
      wake_flag <= wake_event | (wake_flag & !(ext_flag_wr && !ext_flag_wdata[`XF_WF]));
      kick_flag <= kick_event | (kick_flag & !(ext_flag_wr && !ext_flag_wdata[`XF_KF]));
      ram_clear_flag <= ram_clear_event | (ram_clear_flag & !(ext_flag_wr && !ext_flag_wdata[`XF_RF]));
    end
  end

  // ****************************************************************************
  // interrupt request
  // ****************************************************************************
  // enables are looked at in their next value so a write that enables a
  // source with a stale flag pulls the pin the very next edge
  assign next_periodic_en = (reg_b_wr) ? reg_b_wdata[`CB_PIE] : periodic_int_en;
  assign next_alarm_en = (reg_b_wr) ? reg_b_wdata[`CB_AIE] : alarm_int_en;
  assign next_wake_en = (ext_ctrl_wr) ? ext_ctrl_wdata[`XC_WIE] : wake_int_en;
  assign next_kick_en = (ext_ctrl_wr) ? ext_ctrl_wdata[`XC_KSE] : kick_int_en;
  assign next_ram_en = (ext_ctrl_wr) ? ext_ctrl_wdata[`XC_RIE] : ram_clear_int_en;
  assign next_pending = (periodic_flag && next_periodic_en) || (alarm_flag && next_alarm_en)
    || (update_done_flag && (reg_b_wr ? next_update_en : update_int_en))
    || (wake_flag && next_wake_en) || (kick_flag && next_kick_en)
    || (ram_clear_flag && next_ram_en);

  // pin enable and pending flag share one next value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_pending_flag <= 1'b0;
      irq_n_oe <= 1'b0;
      irq_n_out <= 1'b0;
    end else if (ce) begin
      int_pending_flag <= next_pending;
      irq_n_oe <= next_pending;
      irq_n_out <= 1'b0; // open drain: only ever drives low
    end
  end

  // ****************************************************************************
  // square wave
  // ****************************************************************************
  // without main supply only the fast clock survives, on aux battery
  always_comb begin
    if (!main_power_ok) begin
      next_square = fast_clk_out_sel && aux_batt_enable && aux_battery_in && div.chain[0];
    end else if (fast_clk_out_sel) begin
      next_square = div.chain[0];
    end else if (square_out_en) begin
      next_square = div.tap;
    end else begin
      next_square = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      square_out_pin <= 1'b0;
    end else if (ce) begin
      square_out_pin <= next_square;
    end
  end

  // ****************************************************************************
  // readback
  // ****************************************************************************
  // flag readback tracks while idle, freezes during a read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_a_rd <= 8'h00;
      reg_b_rd <= 8'h00;
      primary_flag_rd <= 8'h00;
      ext_ctrl_rd <= 8'h00;
      ext_flag_rd <= 8'h00;
    end else if (ce) begin
      reg_a_rd <= {update_pending, divider_ctrl, rate_select};
      reg_b_rd <= {freeze, periodic_int_en, alarm_int_en, update_int_en, square_out_en, 3'h0};
      ext_ctrl_rd <= {aux_batt_enable, fast_clk_out_sel, 3'h0, wake_int_en, kick_int_en, ram_clear_int_en};
      ext_flag_rd <= {5'h00, wake_flag, kick_flag, ram_clear_flag};
      if (rd_state == RD_IDLE && !flag_rd) begin
        primary_flag_rd <= {int_pending_flag, periodic_flag, alarm_flag, update_done_flag, 4'h0};
      end
    end
  end

endmodule : rtc_irq_sqw_update_ctrl

// ==== rtc_host_model.sv ====
// host side model that runs primary flag read cycles
`timescale 1ns/1ps
module rtc_host_model #(
  parameter int RD_LEN = 70
) (
  // clock
  input wire logic clk_sys,
  // read request from the bench
  input wire logic rd_go,
  input wire rtc_pkg::byte_t primary_flag_rd,
  // read strobe and what the host saw
  output logic flag_rd,
  output logic rd_busy,
  output rtc_pkg::byte_t first_seen,
  output rtc_pkg::byte_t last_seen
);
  import rtc_pkg::*;
  int cnt = 0;
  initial begin
    flag_rd = 1'b0;
    rd_busy = 1'b0;
  end
  // ****************************************************************************
  // read cycle: strobe held throughout, whole byte kept so no flag is lost
  // ****************************************************************************
  always @(posedge clk_sys) begin
    if (rd_go && !rd_busy) begin
      rd_busy <= 1'b1;
      flag_rd <= 1'b1;
      cnt <= 0;
    end else if (rd_busy) begin
      cnt <= cnt + 1;
      if (cnt == 1) first_seen <= primary_flag_rd;
      if (cnt == RD_LEN - 1) begin
        flag_rd <= 1'b0;
        rd_busy <= 1'b0;
        last_seen <= primary_flag_rd;
      end
    end
  end
endmodule : rtc_host_model

// ==== rtc_irq_checker.sv ====
// concurrent checks on the request, square-wave and update outputs
`timescale 1ns/1ps
module rtc_irq_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // supplies and control writes
  input wire logic main_power_ok,
  input wire logic aux_battery_in,
  input wire logic reg_b_wr,
  input wire rtc_pkg::byte_t reg_b_wdata,
  input wire logic ext_ctrl_wr,
  input wire rtc_pkg::byte_t ext_ctrl_wdata,
  input wire logic ext_flag_wr,
  // readback and pins
  input wire rtc_pkg::byte_t reg_a_rd,
  input wire rtc_pkg::byte_t reg_b_rd,
  input wire rtc_pkg::byte_t primary_flag_rd,
  input wire rtc_pkg::byte_t ext_ctrl_rd,
  input wire rtc_pkg::byte_t ext_flag_rd,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic square_out_pin
);
  import rtc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ****************************************************************************
  // request pin and flags
  // ****************************************************************************
  a_pin_low: assert property (irq_n_oe |-> !irq_n_out)
    else $error("pin not low");
  a_ext_src_irq: assert property (|(ext_flag_rd[2:0] & ext_ctrl_rd[2:0]) |-> irq_n_oe)
    else $error("no request");
  a_masked_quiet: assert property (irq_n_oe |=> |{reg_b_rd[6:4], ext_ctrl_rd[2:0]})
    else $error("request while masked");
  a_stale_enable: assert property (ext_ctrl_wr && |(ext_ctrl_wdata[2:0] & ext_flag_rd[2:0]) |-> ##[1:3] irq_n_oe)
    else $error("stale flag ignored");
  a_ext_flag_hold: assert property (!$past(rst) && |($past(ext_flag_rd[2:0]) & ~ext_flag_rd[2:0])
    |-> $past(ext_flag_wr, 2))
    else $error("flag lost");
  a_freeze_uie: assert property (reg_b_wr && reg_b_wdata[7] && !reg_b_rd[7] |-> ##2 !reg_b_rd[4])
    else $error("update enable kept");
  // square output and update pulse; the divider is assumed ticked every cycle
  a_square_off: assert property ((!reg_b_rd[3] && !ext_ctrl_rd[6]) [*3] |-> !square_out_pin)
    else $error("square not low");
  a_fast_toggle: assert property ((ext_ctrl_rd[6] && main_power_ok && reg_a_rd[6:5] == 2'b01) [*4]
    |-> square_out_pin != $past(square_out_pin))
    else $error("fast square idle");
  a_no_power: assert property ((!main_power_ok && !(ext_ctrl_rd[7] && aux_battery_in)) [*3] |-> !square_out_pin)
    else $error("square unpowered");
  a_uip_pulse: assert property ($rose(reg_a_rd[7]) |-> reg_a_rd[7] [*8] ##[1:12] !reg_a_rd[7])
    else $error("pending pulse length");
  a_update_done: assert property ($rose(reg_a_rd[7]) |-> ##[12:22] primary_flag_rd[4])
    else $error("update done missing");
  c_irq: cover property ($rose(irq_n_oe));
  c_uip: cover property ($rose(reg_a_rd[7]));
  c_ext_clear: cover property ($fell(ext_flag_rd[2]));
endmodule : rtc_irq_checker

// ==== testbench.sv ====
// self-checking bench for the rtc interrupt block
`timescale 1ns/1ps
module testbench;
  import rtc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic main_power_ok = 1'b1;
  logic aux_battery_in = 1'b0;
  logic [3:0] wr_sel = 4'h0;
  logic [2:0] ev = 3'h0;
  logic time_load = 1'b0;
  logic rd_go = 1'b0;
  byte_t wd = 8'h00, tin = 8'h00, alarm_sec = 8'h00, alm_hi = 8'hc0;
  byte_t reg_a_rd, reg_b_rd, primary_flag_rd, ext_ctrl_rd, ext_flag_rd, time_sec, first_seen, last_seen;
  logic irq_n_out, irq_n_oe, square_out_pin, flag_rd, rd_busy;
  int error_cnt = 0, cmp_count = 0, cycles = 0;
  always #25 clk_sys = ~clk_sys;
  rtc_irq_sqw_update_ctrl u_dut (.clk_sys, .rst, .ce(1'b1), .osc_tick(1'b1), .main_power_ok, .aux_battery_in,
    .reg_a_wr(wr_sel[0]), .reg_a_wdata(wd), .reg_b_wr(wr_sel[1]), .reg_b_wdata(wd), .ext_ctrl_wr(wr_sel[2]),
    .ext_ctrl_wdata(wd), .ext_flag_wr(wr_sel[3]), .ext_flag_wdata(wd), .flag_rd, .wake_event(ev[2]),
    .kick_event(ev[1]), .ram_clear_event(ev[0]), .time_load, .time_in_sec(tin), .time_in_min(tin),
    .time_in_hr(tin), .alarm_sec, .alarm_min(alm_hi), .alarm_hr(alm_hi), .reg_a_rd, .reg_b_rd,
    .primary_flag_rd, .ext_ctrl_rd, .ext_flag_rd, .time_sec, .time_min(), .time_hr(), .irq_n_out, .irq_n_oe,
    .square_out_pin);
  rtc_host_model u_host (.clk_sys, .rd_go, .primary_flag_rd, .flag_rd, .rd_busy, .first_seen, .last_seen);
  // ****************************************************************************
  // access tasks
  // ****************************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // select: 0 rate, 1 control, 2 ext control, 3 ext flags
  task automatic wr(input int k, input logic [7:0] d);
    @(posedge clk_sys);
    wd <= d;
    wr_sel <= 4'h1 << k;
    @(posedge clk_sys);
    wr_sel <= 4'h0;
    cyc(3);
  endtask : wr
  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev <= 3'h1 << k;
    @(posedge clk_sys);
    ev <= 3'h0;
    cyc(3);
  endtask : pulse
  task automatic host_read;
    @(posedge clk_sys);
    rd_go <= 1'b1;
    @(posedge clk_sys);
    rd_go <= 1'b0;
    cyc(2);
    repeat (100) if (rd_busy === 1'b1) @(negedge clk_sys);
  endtask : host_read
  // high-phase length of the square pin, bounded against a dead pin
  task automatic half(output int n);
    n = 0;
    repeat (600) if (square_out_pin !== 1'b0) @(negedge clk_sys);
    repeat (600) if (square_out_pin !== 1'b1) @(negedge clk_sys);
    while (square_out_pin === 1'b1 && n < 600) begin
      n++;
      @(negedge clk_sys);
    end
  endtask : half
  task automatic tog(output int n);
    logic p;
    n = 0;
    repeat (8) begin
      p = square_out_pin;
      @(negedge clk_sys);
      n += int'(square_out_pin !== p);
    end
  endtask : tog
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // hang guard beyond the half-second update wait
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 45000) begin
      error_cnt++;
      final_report();
    end
  end
  // ****************************************************************************
  // scenarios
  // ****************************************************************************
  initial begin
    int n, c;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(3);
    chk(reg_a_rd, 8'h20);
    chk(reg_b_rd, 8'h08);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      chk(ext_flag_rd, 8'h01 << i);
      chk(irq_n_oe, 1'b0);
      host_read();
      chk(ext_flag_rd, 8'h01 << i);
      wr(2, 8'h01 << i);
      chk(irq_n_oe, 1'b1);
      chk(primary_flag_rd[7], 1'b1);
      wr(3, ~(8'h01 << i));
      chk({ext_flag_rd, irq_n_oe, primary_flag_rd[7]}, 16'h0);
      wr(2, 8'h00);
    end
    wr(0, 8'h26);
    cyc(70);
    chk(primary_flag_rd[6], 1'b1);
    chk(irq_n_oe, 1'b0);
    wr(1, 8'h48);
    chk(irq_n_oe, 1'b1);
    host_read();
    chk(last_seen, first_seen);
    cyc(2);
    chk(primary_flag_rd[6], 1'b1);
    wr(0, 8'h20);
    host_read();
    cyc(2);
    chk({primary_flag_rd, irq_n_oe}, 16'h0);
    for (c = 1; c < 9; c++) begin
      wr(0, {4'h2, c[3:0]});
      half(n);
      chk(n[15:0], 16'h1 << (c == 1 ? 7 : c == 2 ? 8 : c - 1));
    end
    wr(0, 8'h20);
    tog(n);
    chk(n[15:0], 16'h0);
    wr(0, 8'h23);
    wr(1, 8'h00);
    tog(n);
    chk(n[15:0], 16'h0);
    wr(2, 8'h40);
    half(n);
    chk(n[15:0], 16'h1);
    for (c = 0; c < 8; c++) begin
      wr(0, {1'b0, c[2:0], 4'h3});
      tog(n);
      chk(n[15:0], c[2:1] == 2'b01 ? 16'h8 : 16'h0);
    end
    wr(0, 8'h20);
    @(posedge clk_sys);
    main_power_ok <= 1'b0;
    wr(2, 8'hc0);
    tog(n);
    chk(n[15:0], 16'h0);
    @(posedge clk_sys);
    aux_battery_in <= 1'b1;
    cyc(3);
    tog(n);
    chk(n[15:0], 16'h8);
    @(posedge clk_sys);
    main_power_ok <= 1'b1;
    aux_battery_in <= 1'b0;
    wr(2, 8'h00);
    wr(1, 8'h30);
    wr(1, 8'hb0);
    chk(reg_b_rd, 8'ha0);
    wr(1, 8'h20);
    @(posedge clk_sys);
    time_load <= 1'b1;
    alarm_sec <= 8'h01;
    @(posedge clk_sys);
    time_load <= 1'b0;
    host_read();
    wr(0, 8'h60);
    wr(0, 8'h20);
    n = 0;
    while (primary_flag_rd[4] !== 1'b1 && n < 40000) begin
      n++;
      @(negedge clk_sys);
    end
    chk(n > 32760 && n < 32780, 1'b1);
    cyc(2);
    chk(primary_flag_rd, 8'hb0);
    chk(time_sec, 8'h01);
    host_read();
    cyc(2);
    chk(irq_n_oe, 1'b0);
    final_report();
  end
endmodule : testbench
bind rtc_irq_sqw_update_ctrl rtc_irq_checker u_chk (.clk_sys, .rst, .main_power_ok, .aux_battery_in, .reg_b_wr,
  .reg_b_wdata, .ext_ctrl_wr, .ext_ctrl_wdata, .ext_flag_wr, .reg_a_rd, .reg_b_rd, .primary_flag_rd, .ext_ctrl_rd,
  .ext_flag_rd, .irq_n_out, .irq_n_oe, .square_out_pin);
